/* File: rtl/tbg_regs.svh */
// constants for the transducer burst generator: timing counts and host register map
// assumes a 25 MHz system clock on both ends
`ifndef TBG_REGS_SVH
`define TBG_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TBG_CLK_NS        40
`define TBG_DT_STEP_NS    1000
`define TBG_DT_STEP_CYC   ((`TBG_DT_STEP_NS + `TBG_CLK_NS - 1) / `TBG_CLK_NS)
`define TBG_INT_HALF_NS   400
`define TBG_INT_HALF_CYC  (`TBG_INT_HALF_NS / `TBG_CLK_NS)
`define TBG_DT_OFF        3'h7

// ----------------------------------------------------------------
// host register map (byte offsets) and fields
// ----------------------------------------------------------------
`define TBG_REG_CTRL      4'h0
`define TBG_REG_PERIODS   4'h4
`define TBG_REG_DIV       4'h8
`define TBG_REG_STATUS    4'hC
`define TBG_CTRL_MODE_LSB 0
`define TBG_CTRL_GO_BIT   2
`define TBG_PERIODS_RST   8'h04
`define TBG_DIV_RST       8'h04
`define TBG_LINK_IDLE     3'h3

`endif

/* File: rtl/tbg_pkg.sv */
// types shared by both ends of the transducer burst link
// assumes the constants header is included where counts are needed
package tbg_pkg;

	// excitation modes, in the order of their two-bit select codes
	typedef enum logic [1:0] {
		TBG_MODE_SW,
		TBG_MODE_PIN,
		TBG_MODE_DIRECT,
		TBG_MODE_SINGLE
	} tbg_mode_t;

	// device burst sequencer
	typedef enum logic [2:0] {
		TBG_ST_IDLE,
		TBG_ST_ENABLED,
		TBG_ST_BURST,
		TBG_ST_BLANK,
		TBG_ST_REARM
	} tbg_dev_state_t;

	// host clock sequencer
	typedef enum logic [2:0] {
		TBG_HS_IDLE,
		TBG_HS_LEAD,
		TBG_HS_LOW,
		TBG_HS_HIGH,
		TBG_HS_TAIL
	} tbg_host_state_t;

endpackage : tbg_pkg

/* File: rtl/tbg_link_if.sv */
// link between the burst controller and the burst device
// assumes the bench joins one controller and one device on it
`timescale 1ns/100ps

interface tbg_link_if;
	logic ctrl_pin_a;   // controller drive pin a
	logic ctrl_pin_b;   // controller drive pin b, burst clock
	logic sw_trigger;   // serial trigger bit as a level
	logic bridge_out_p; // bridge output p
	logic bridge_out_n; // bridge output n

	modport dev (
		input  ctrl_pin_a,
		input  ctrl_pin_b,
		input  sw_trigger,
		output bridge_out_p,
		output bridge_out_n
	);

	modport host (
		output ctrl_pin_a,
		output ctrl_pin_b,
		output sw_trigger,
		input  bridge_out_p,
		input  bridge_out_n
	);
endinterface : tbg_link_if

/* File: rtl/tbg_sync.sv */
// two-flop level synchroniser, one per bit
// assumes inputs are asynchronous levels; the first stage feeds only the second
`timescale 1ns/100ps

module tbg_sync #(
	parameter int           WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	// ----------------------------------------------------------------
	// synchroniser stages
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// two stages, only the second reads the first
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_ff[gi] <= RST_VAL[gi];
					q[gi]       <= RST_VAL[gi];
				end else begin
					meta_ff[gi] <= d[gi];
					q[gi]       <= meta_ff[gi];
				end
			end
		end
	endgenerate
endmodule : tbg_sync

/* File: rtl/tbg_device.sv */
// burst generator device end: turns controller pin activity into bridge drive
// assumes pins and trigger arrive asynchronously; configuration inputs are static levels
// Notes on behaviour
// - burst clock from pins, mode picks behaviour
// - enable first, start at next falling edge; mode 3 does both on one b fall
// - mode 0: trigger enables, first b fall starts
// - count pulses between b falling edges
// - mode 0 ends on count or trigger low
// - mode 0 rearms on trigger low then high
// - mode 1: a low enables, b fall starts
// - mode 1 ends on count or a high
// - controller keeps pin b high before enable
// - mode 2: any fall enables, a fall starts
// - mode 2 outputs follow pins, count ignored
// - mode 2 both high too long ends burst
// - controller drives pins without overlap
// - mode 3: b fall enables and starts
// - mode 3 blank-out after burst ignores b
// - zero count bursts continuously, not mode 3
// - short count at end sets count fault
// - no toggle within timeout forces stuck fault
// - stuck with short count also count fault
// - stuck flag clears: start, timeout 7, standby
// - count flag clears: start, standby
// - pre-driver mode drives external low-side devices
`timescale 1ns/100ps
`include "tbg_regs.svh"

module tbg_device #(
	parameter int CNT_W   = 6,
	parameter int OVL_CYC = `TBG_INT_HALF_CYC
) (
	input  wire logic              MCLK,
	input  wire logic              RST,
	tbg_link_if.dev                LINK,
	input  wire logic [1:0]        MODE,
	input  wire logic [CNT_W-1:0]  PULSE_CFG,
	input  wire logic [2:0]        DRIVE_TIMEOUT_CFG,
	input  wire logic              PRE_DRIVER,
	input  wire logic              STANDBY,
	output logic                   STUCK_DRIVE_FLAG,
	output logic                   COUNT_FAULT_FLAG,
	output logic                   BURST_ACTIVE
);
	localparam logic [7:0] DT_STEP = 8'(`TBG_DT_STEP_CYC);
	localparam logic [7:0] OVL_LIM = 8'(OVL_CYC);

	tbg_pkg::tbg_mode_t      mode;
	tbg_pkg::tbg_dev_state_t state_ff;
	tbg_pkg::tbg_dev_state_t nxt_state;
	logic [2:0]              pins_s;
	logic [2:0]              prev_ff;
	logic [CNT_W-1:0]        count_ff;
	logic [CNT_W-1:0]        target;
	logic [7:0]              timer_ff;
	logic [7:0]              ovl_ff;
	logic [7:0]              dt_lim;
	logic                    a_s;
	logic                    b_s;
	logic                    trig_s;
	logic                    a_fall;
	logic                    a_rise;
	logic                    b_fall;
	logic                    toggle;
	logic                    counted;
	logic                    count_hit;
	logic                    reached;
	logic                    start;
	logic                    end_ext;
	logic                    end_stuck;
	logic                    dt_on;
	logic                    out_p_ff;
	logic                    out_n_ff;

	assign mode = tbg_pkg::tbg_mode_t'(MODE);

	// ----------------------------------------------------------------
	// pin capture and edge detection
	// ----------------------------------------------------------------
	// pins idle high through pull-ups, trigger idles low
	tbg_sync #(
		.WIDTH   (3),
		.RST_VAL (`TBG_LINK_IDLE)
	) u_sync (
		.clk (MCLK),
		.rst (RST),
		.d   ({LINK.sw_trigger, LINK.ctrl_pin_b, LINK.ctrl_pin_a}),
		.q   (pins_s)
	);

	// previous synchronised levels for edge finding
	always_ff @(posedge MCLK) begin
		if (RST) begin
			prev_ff <= `TBG_LINK_IDLE;
		end else begin
			prev_ff <= pins_s;
		end
	end

	assign a_s    = pins_s[0];
	assign b_s    = pins_s[1];
	assign trig_s = pins_s[2];
	assign a_fall = prev_ff[0] & ~a_s;
	assign a_rise = ~prev_ff[0] & a_s;
	assign b_fall = prev_ff[1] & ~b_s;
	// mode 2 watches both pins, the others only the clock pin
	assign toggle = (mode == tbg_pkg::TBG_MODE_DIRECT) ? |(prev_ff[1:0] ^ pins_s[1:0])
	                                                   : (prev_ff[1] ^ b_s);

	// ----------------------------------------------------------------
	// pulse target, timeout limit and end conditions
	// ----------------------------------------------------------------
	assign counted = (mode != tbg_pkg::TBG_MODE_DIRECT);
	// a zero count in mode 3 cannot run forever, it sends one pulse
	assign target  = (PULSE_CFG == '0 && mode == tbg_pkg::TBG_MODE_SINGLE) ? CNT_W'(1)
	                                                                       : PULSE_CFG;
	assign count_hit = counted && target != '0 && b_fall
	                   && (count_ff + CNT_W'(1)) == target;
	assign reached = (target == '0) || (count_ff >= target);
	assign dt_on   = (DRIVE_TIMEOUT_CFG != `TBG_DT_OFF);
	assign dt_lim  = 8'({5'h00, DRIVE_TIMEOUT_CFG} + 8'h01) * DT_STEP;
	assign end_stuck = (state_ff == tbg_pkg::TBG_ST_BURST) && dt_on
	                   && !toggle && timer_ff >= dt_lim;

	// early ends signalled by software or pins
	always_comb begin
		end_ext = 1'b0;
		if (state_ff == tbg_pkg::TBG_ST_BURST) begin
			case (mode)
				tbg_pkg::TBG_MODE_SW:     end_ext = !trig_s;
				tbg_pkg::TBG_MODE_PIN:    end_ext = a_rise || a_s;
				tbg_pkg::TBG_MODE_DIRECT: end_ext = a_s && b_s && ovl_ff >= OVL_LIM;
				default:                  end_ext = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// next state; start is the burst's first edge
	always_comb begin
		nxt_state = state_ff;
		start     = 1'b0;
		case (state_ff)
			tbg_pkg::TBG_ST_IDLE: begin
				case (mode)
					tbg_pkg::TBG_MODE_SW:
						if (trig_s) nxt_state = tbg_pkg::TBG_ST_ENABLED;
					tbg_pkg::TBG_MODE_PIN:
						if (a_fall) nxt_state = tbg_pkg::TBG_ST_ENABLED;
					tbg_pkg::TBG_MODE_DIRECT:
						if (a_fall || b_fall) nxt_state = tbg_pkg::TBG_ST_ENABLED;
					default:
						if (b_fall) begin
							nxt_state = tbg_pkg::TBG_ST_BURST;
							start     = 1'b1;
						end
				endcase
			end
			tbg_pkg::TBG_ST_ENABLED: begin
				if ((mode == tbg_pkg::TBG_MODE_SW && !trig_s)
				    || (mode == tbg_pkg::TBG_MODE_PIN && a_s)) begin
					nxt_state = tbg_pkg::TBG_ST_IDLE;
				end else if (mode == tbg_pkg::TBG_MODE_DIRECT ? a_fall : b_fall) begin
					nxt_state = tbg_pkg::TBG_ST_BURST;
					start     = 1'b1;
				end
			end
			tbg_pkg::TBG_ST_BURST: begin
				if (end_ext || end_stuck || count_hit) begin
					case (mode)
						tbg_pkg::TBG_MODE_SINGLE: nxt_state = tbg_pkg::TBG_ST_BLANK;
						tbg_pkg::TBG_MODE_DIRECT: nxt_state = tbg_pkg::TBG_ST_IDLE;
						default:                  nxt_state = tbg_pkg::TBG_ST_REARM;
					endcase
				end
			end
			tbg_pkg::TBG_ST_BLANK: begin
				if (timer_ff >= (dt_on ? dt_lim : DT_STEP)) begin
					nxt_state = tbg_pkg::TBG_ST_IDLE;
				end
			end
			tbg_pkg::TBG_ST_REARM: begin
				// the enabling level must drop before a new burst is taken
				if ((mode == tbg_pkg::TBG_MODE_SW) ? !trig_s : a_s) begin
					nxt_state = tbg_pkg::TBG_ST_IDLE;
				end
			end
			default: nxt_state = tbg_pkg::TBG_ST_IDLE;
		endcase
		if (STANDBY) begin
			nxt_state = tbg_pkg::TBG_ST_IDLE;
			start     = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_ff <= tbg_pkg::TBG_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// pulse counter, one per falling-to-falling interval on pin b
	always_ff @(posedge MCLK) begin
		if (RST || start) begin
			count_ff <= '0;
		end else if (state_ff == tbg_pkg::TBG_ST_BURST && counted && b_fall
		             && count_ff != '1) begin
			count_ff <= count_ff + CNT_W'(1);
		end
	end

	// shared timer: time since last toggle in a burst, blank-out after it
	always_ff @(posedge MCLK) begin
		if (RST || start || nxt_state != state_ff
		    || (state_ff == tbg_pkg::TBG_ST_BURST && toggle)) begin
			timer_ff <= 8'h00;
		end else if (timer_ff != 8'hFF) begin
			timer_ff <= timer_ff + 8'h01;
		end
	end

	// overlap timer: both pins high inside a burst of any mode, read only in mode 2
	always_ff @(posedge MCLK) begin
		if (RST || !(a_s && b_s) || state_ff != tbg_pkg::TBG_ST_BURST) begin
			ovl_ff <= 8'h00;
		end else if (ovl_ff != 8'hFF) begin
			ovl_ff <= ovl_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// fault flags: a set in the clearing cycle wins
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RST) begin
			STUCK_DRIVE_FLAG <= 1'b0;
		end else if (end_stuck) begin
			STUCK_DRIVE_FLAG <= 1'b1;
		end else if (start || !dt_on || STANDBY) begin
			STUCK_DRIVE_FLAG <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			COUNT_FAULT_FLAG <= 1'b0;
		end else if (counted && !reached && (end_ext || end_stuck)) begin
			COUNT_FAULT_FLAG <= 1'b1;
		end else if (start || STANDBY) begin
			COUNT_FAULT_FLAG <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// bridge drive
	// ----------------------------------------------------------------
	// lookup {p, n}; pre-driver swaps phases for the external low-side pair
	function automatic logic [1:0] drive_lut(input tbg_pkg::tbg_mode_t m, input logic pre,
	                                         input logic a, input logic b);
		logic [1:0] v;
		v = (m == tbg_pkg::TBG_MODE_DIRECT) ? {~a, ~b} : {~b, b};
		drive_lut = pre ? {v[0], v[1]} : v;
	endfunction : drive_lut

	// outputs rest low, bridge off, whenever no burst runs
	always_ff @(posedge MCLK) begin
		if (RST || nxt_state != tbg_pkg::TBG_ST_BURST) begin
			{out_p_ff, out_n_ff} <= 2'h0;
		end else begin
			{out_p_ff, out_n_ff} <= drive_lut(mode, PRE_DRIVER, a_s, b_s);
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			BURST_ACTIVE <= 1'b0;
		end else begin
			BURST_ACTIVE <= (nxt_state == tbg_pkg::TBG_ST_BURST);
		end
	end

	assign LINK.bridge_out_p = out_p_ff;
	assign LINK.bridge_out_n = out_n_ff;
endmodule : tbg_device

/* File: rtl/tbg_host.sv */
// burst controller end: classic wishbone slave that plays the drive pins
// assumes a wishbone master on the same clock; pin b clock comes from a divider here
`timescale 1ns/100ps
`include "tbg_regs.svh"

module tbg_host (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	tbg_link_if.host         LINK
);
	tbg_pkg::tbg_host_state_t state_ff;
	tbg_pkg::tbg_host_state_t nxt_state;
	tbg_pkg::tbg_mode_t       mode_ff;
	logic [7:0]               periods_ff;
	logic [7:0]               div_ff;
	logic [7:0]               left_ff;
	logic [7:0]               tick_ff;
	logic                     go;
	logic                     wr;
	logic                     tick;
	logic                     sel_ff;
	logic                     a_ff;
	logic                     b_ff;
	logic                     trig_ff;

	// ----------------------------------------------------------------
	// wishbone slave, ack one cycle after the strobe
	// ----------------------------------------------------------------
	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
	assign go = wr && WB_ADR_I == `TBG_REG_CTRL && WB_DAT_I[`TBG_CTRL_GO_BIT]
	            && state_ff == tbg_pkg::TBG_HS_IDLE;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
		end
	end

	// register writes, low byte lane only; mode is locked while busy
	always_ff @(posedge MCLK) begin
		if (RST) begin
			mode_ff    <= tbg_pkg::TBG_MODE_SW;
			periods_ff <= `TBG_PERIODS_RST;
			div_ff     <= `TBG_DIV_RST;
		end else if (wr && state_ff == tbg_pkg::TBG_HS_IDLE) begin
			case (WB_ADR_I)
				`TBG_REG_CTRL:    mode_ff    <= tbg_pkg::tbg_mode_t'(WB_DAT_I[1:0]);
				`TBG_REG_PERIODS: periods_ff <= WB_DAT_I[7:0];
				`TBG_REG_DIV:     div_ff     <= (WB_DAT_I[7:0] == 8'h00) ? 8'h01 : WB_DAT_I[7:0];
				default:          ;
			endcase
		end
	end

	// read data; unmapped offsets read zero
	always_ff @(posedge MCLK) begin
		if (RST) begin
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			case (WB_ADR_I)
				`TBG_REG_CTRL:    WB_DAT_O <= {30'h0000_0000, mode_ff};
				`TBG_REG_PERIODS: WB_DAT_O <= {24'h00_0000, periods_ff};
				`TBG_REG_DIV:     WB_DAT_O <= {24'h00_0000, div_ff};
				`TBG_REG_STATUS:  WB_DAT_O <= {15'h0000, left_ff, 6'h00,
				                              LINK.bridge_out_p, LINK.bridge_out_n,
				                              state_ff != tbg_pkg::TBG_HS_IDLE};
				default:          WB_DAT_O <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin sequencer: every phase lasts div_ff cycles
	// ----------------------------------------------------------------
	assign tick = (tick_ff == div_ff - 8'h01);

	always_ff @(posedge MCLK) begin
		if (RST || go || tick || state_ff == tbg_pkg::TBG_HS_IDLE) begin
			tick_ff <= 8'h00;
		end else begin
			tick_ff <= tick_ff + 8'h01;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tbg_pkg::TBG_HS_IDLE: if (go) nxt_state = tbg_pkg::TBG_HS_LEAD;
			tbg_pkg::TBG_HS_LEAD: if (tick) nxt_state = tbg_pkg::TBG_HS_LOW;
			tbg_pkg::TBG_HS_LOW:  if (tick) nxt_state = tbg_pkg::TBG_HS_HIGH;
			tbg_pkg::TBG_HS_HIGH: begin
				if (tick) begin
					nxt_state = (left_ff <= 8'h01) ? tbg_pkg::TBG_HS_TAIL : tbg_pkg::TBG_HS_LOW;
				end
			end
			tbg_pkg::TBG_HS_TAIL: if (tick) nxt_state = tbg_pkg::TBG_HS_IDLE;
			default:              nxt_state = tbg_pkg::TBG_HS_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_ff <= tbg_pkg::TBG_HS_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// low phases still to play; mode 2 alternates b and a starting with b
	always_ff @(posedge MCLK) begin
		if (RST) begin
			left_ff <= 8'h00;
			sel_ff  <= 1'b0;
		end else if (go) begin
			left_ff <= periods_ff;
			sel_ff  <= 1'b0;
		end else if (state_ff == tbg_pkg::TBG_HS_HIGH && tick) begin
			left_ff <= left_ff - 8'h01;
			sel_ff  <= ~sel_ff;
		end
	end

	// pin levels; b rests high before enable so the count starts clean
	always_ff @(posedge MCLK) begin
		if (RST) begin
			a_ff    <= 1'b1;
			b_ff    <= 1'b1;
			trig_ff <= 1'b0;
		end else begin
			trig_ff <= mode_ff == tbg_pkg::TBG_MODE_SW
			           && nxt_state != tbg_pkg::TBG_HS_IDLE
			           && nxt_state != tbg_pkg::TBG_HS_TAIL;
			if (mode_ff == tbg_pkg::TBG_MODE_DIRECT) begin
				// one pin low at a time, never both: no overlap
				a_ff <= !(nxt_state == tbg_pkg::TBG_HS_LOW && sel_ff);
				b_ff <= !(nxt_state == tbg_pkg::TBG_HS_LOW && !sel_ff);
			end else begin
				a_ff <= !(mode_ff == tbg_pkg::TBG_MODE_PIN
				          && nxt_state != tbg_pkg::TBG_HS_IDLE
				          && nxt_state != tbg_pkg::TBG_HS_TAIL);
				b_ff <= nxt_state != tbg_pkg::TBG_HS_LOW;
			end
		end
	end

	assign LINK.ctrl_pin_a = a_ff;
	assign LINK.ctrl_pin_b = b_ff;
	assign LINK.sw_trigger = trig_ff;
endmodule : tbg_host

/* File: verification/tbg_link_assertions.sv */
// checker for the burst link: pins between controller and device, plus device status
// assumes one clock domain, MCLK, with synchronous active-high RST
`timescale 1ns/100ps

module tbg_link_chk #(
	parameter int OVL_CYC = 10
) (
	input wire logic       MCLK,
	input wire logic       RST,
	input wire logic       ctrl_pin_a,
	input wire logic       ctrl_pin_b,
	input wire logic       sw_trigger,
	input wire logic       bridge_out_p,
	input wire logic       bridge_out_n,
	input wire logic [1:0] MODE,
	input wire logic [2:0] DRIVE_TIMEOUT_CFG,
	input wire logic       PRE_DRIVER,
	input wire logic       STANDBY,
	input wire logic       STUCK_DRIVE_FLAG,
	input wire logic       COUNT_FAULT_FLAG,
	input wire logic       BURST_ACTIVE
);
	// ----------------------------------------------------------------
	// helper counters
	// ----------------------------------------------------------------
	logic [7:0] hi_cnt_ff;
	logic [7:0] quiet_cnt_ff;
	logic [7:0] since_end_ff;
	logic       act_ff;
	logic       a_ff;
	logic       b_ff;
	int         lim;

	assign lim = (int'(DRIVE_TIMEOUT_CFG) + 1) * 25;

	// cycles with both pins high, saturating
	always_ff @(posedge MCLK) begin
		hi_cnt_ff <= (RST || !(ctrl_pin_a && ctrl_pin_b)) ? 8'h00 : hi_cnt_ff + (hi_cnt_ff != 8'hFF);
	end

	// cycles in burst without any pin change
	always_ff @(posedge MCLK) begin
		a_ff <= ctrl_pin_a;
		b_ff <= ctrl_pin_b;
		if (RST || !BURST_ACTIVE || a_ff != ctrl_pin_a || b_ff != ctrl_pin_b) begin
			quiet_cnt_ff <= 8'h00;
		end else if (quiet_cnt_ff != 8'hFF) begin
			quiet_cnt_ff <= quiet_cnt_ff + 8'h01;
		end
	end

	// cycles since the last end of burst; reset counts as long ago
	always_ff @(posedge MCLK) begin
		act_ff <= BURST_ACTIVE;
		if (RST) begin
			since_end_ff <= 8'hFF;
		end else if (act_ff && !BURST_ACTIVE) begin
			since_end_ff <= 8'h00;
		end else if (since_end_ff != 8'hFF) begin
			since_end_ff <= since_end_ff + 8'h01;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_IDLE_OFF: assert property (
		!BURST_ACTIVE |-> !bridge_out_p && !bridge_out_n) else $error("bridge driven while idle");
	AST_MAP_CLOCKED: assert property (
		BURST_ACTIVE && $past(BURST_ACTIVE) && MODE != 2'h2 |->
		bridge_out_p == ($past(ctrl_pin_b, 3) ^ !PRE_DRIVER) && bridge_out_n == !bridge_out_p)
		else $error("clocked mode output map wrong");
	AST_MAP_DIRECT: assert property (
		BURST_ACTIVE && $past(BURST_ACTIVE) && MODE == 2'h2 |->
		bridge_out_p == !(PRE_DRIVER ? $past(ctrl_pin_b, 3) : $past(ctrl_pin_a, 3)) &&
		bridge_out_n == !(PRE_DRIVER ? $past(ctrl_pin_a, 3) : $past(ctrl_pin_b, 3)))
		else $error("direct mode output map wrong");
	AST_SW_ENABLE: assert property (
		$rose(BURST_ACTIVE) && MODE == 2'h0 |-> sw_trigger) else $error("start without trigger");
	AST_PIN_ENABLE: assert property (
		$rose(BURST_ACTIVE) && MODE == 2'h1 |-> !ctrl_pin_a) else $error("start with pin a high");
	AST_SW_END: assert property (
		MODE == 2'h0 && $fell(sw_trigger) |-> ##[1:5] !BURST_ACTIVE) else $error("no end on trigger");
	AST_PIN_END: assert property (
		MODE == 2'h1 && $rose(ctrl_pin_a) |-> ##[1:5] !BURST_ACTIVE) else $error("no end on pin a");
	AST_OVERLAP_END: assert property (
		MODE == 2'h2 && hi_cnt_ff > OVL_CYC + 4 |-> !BURST_ACTIVE) else $error("overlap ignored");
	AST_BLANK_OUT: assert property (
		$rose(BURST_ACTIVE) && MODE == 2'h3 |-> since_end_ff >= 8'h18) else $error("start in blank-out");
	AST_STUCK_END: assert property (
		BURST_ACTIVE && DRIVE_TIMEOUT_CFG != 3'h7 |-> quiet_cnt_ff < lim + 6) else $error("stuck burst");
	AST_DIAG_OFF: assert property (
		DRIVE_TIMEOUT_CFG == 3'h7 ##1 DRIVE_TIMEOUT_CFG == 3'h7 |-> !STUCK_DRIVE_FLAG)
		else $error("stuck flag with diagnostic off");
	AST_STANDBY: assert property (
		STANDBY ##1 STANDBY |-> !STUCK_DRIVE_FLAG && !COUNT_FAULT_FLAG && !BURST_ACTIVE)
		else $error("standby left state");
	AST_DIRECT_NO_COUNT: assert property (
		$rose(COUNT_FAULT_FLAG) |-> MODE != 2'h2) else $error("count fault in direct mode");
	AST_NO_OVERLAP: assert property (
		MODE == 2'h2 |-> ctrl_pin_a || ctrl_pin_b) else $error("both pins low");

	// main scenarios
	COV_SW: cover property ($rose(BURST_ACTIVE) && MODE == 2'h0);
	COV_DIRECT: cover property ($rose(BURST_ACTIVE) && MODE == 2'h2);
	COV_STUCK: cover property ($rose(STUCK_DRIVE_FLAG));
endmodule : tbg_link_chk

/* File: verification/tb_top.sv */
// bench: one controller and one device joined by the link, driven over wishbone
// assumes the rtl files and the link checker are compiled first
`timescale 1ns/100ps
`include "tbg_regs.svh"

module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic [31:0] rd;
	logic        ack;
	logic [1:0]  mode = 2'h0;
	logic [5:0]  pcfg = 6'h02;
	logic [2:0]  tcfg = 3'h3;
	logic        predrv = 1'b0;
	logic        stby = 1'b0;
	logic        stuck;
	logic        cflt;
	logic        active;
	logic        act_q = 1'b0;
	int          n_rise = 0;
	int          cycles = 0;
	int          n_fail = 0;
	int          tests_run = 0;

	tbg_link_if link();
	tbg_host tbg_host_i(.MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
		.LINK(link));
	tbg_device tbg_device_i(.MCLK(mclk), .RST(rst), .LINK(link), .MODE(mode), .PULSE_CFG(pcfg),
		.DRIVE_TIMEOUT_CFG(tcfg), .PRE_DRIVER(predrv), .STANDBY(stby),
		.STUCK_DRIVE_FLAG(stuck), .COUNT_FAULT_FLAG(cflt), .BURST_ACTIVE(active));
	tbg_link_chk #(.OVL_CYC(`TBG_INT_HALF_CYC)) tbg_link_chk_i(.MCLK(mclk), .RST(rst),
		.ctrl_pin_a(link.ctrl_pin_a), .ctrl_pin_b(link.ctrl_pin_b), .sw_trigger(link.sw_trigger),
		.bridge_out_p(link.bridge_out_p), .bridge_out_n(link.bridge_out_n), .MODE(mode),
		.DRIVE_TIMEOUT_CFG(tcfg), .PRE_DRIVER(predrv), .STANDBY(stby),
		.STUCK_DRIVE_FLAG(stuck), .COUNT_FAULT_FLAG(cflt), .BURST_ACTIVE(active));

	always #20 mclk = ~mclk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// burst start counter and hang guard
	always @(posedge mclk) begin
		act_q <= active;
		if (active && !act_q) begin
			n_rise <= n_rise + 1;
		end
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("wishbone ack", {31'h0, ack}, 32'h1);
	endtask : wb

	// program, launch, wait out any blank-out
	task automatic burst(input logic [1:0] m, input logic [5:0] pc, input logic [7:0] per,
		input logic [7:0] dv, input logic cf, input logic sf);
		int r0;
		int k;
		k = 0;
		@(posedge mclk);
		mode <= m;
		pcfg <= pc;
		r0 = n_rise;
		wb(1'b1, `TBG_REG_DIV, {24'h0, dv});
		wb(1'b1, `TBG_REG_PERIODS, {24'h0, per});
		wb(1'b1, `TBG_REG_CTRL, (32'h1 << `TBG_CTRL_GO_BIT) | {30'h0, m});
		do begin
			wb(1'b0, `TBG_REG_STATUS, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 400);
		chk("status at rest", rd, 32'h0);
		repeat (210) @(posedge mclk);
		chk("burst starts", 32'(n_rise - r0), 32'h1);
		chk("count fault", {31'h0, cflt}, {31'h0, cf});
		chk("stuck fault", {31'h0, stuck}, {31'h0, sf});
	endtask : burst

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		chk("idle pins", {29'h0, link.ctrl_pin_a, link.ctrl_pin_b, link.sw_trigger}, 32'h6);
		wb(1'b0, `TBG_REG_PERIODS, 32'h0);
		chk("periods reset", rd, {24'h0, `TBG_PERIODS_RST});
		wb(1'b1, 4'h2, 32'hFF);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped read", rd, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_counted();
		burst(2'h0, 6'h03, 8'h01, 8'h04, 1'b1, 1'b0);
		burst(2'h0, 6'h02, 8'h03, 8'h04, 1'b0, 1'b0);
		burst(2'h1, 6'h03, 8'h01, 8'h04, 1'b1, 1'b0);
		burst(2'h1, 6'h02, 8'h03, 8'h04, 1'b0, 1'b0);
		burst(2'h0, 6'h00, 8'h05, 8'h04, 1'b0, 1'b0);
		$display("test counted modes done");
	endtask : t_counted

	task automatic t_single();
		burst(2'h3, 6'h02, 8'h03, 8'h04, 1'b0, 1'b0);
		burst(2'h3, 6'h00, 8'h02, 8'h04, 1'b0, 1'b0);
		burst(2'h3, 6'h01, 8'h06, 8'h04, 1'b0, 1'b0);
		burst(2'h2, 6'h05, 8'h04, 8'h04, 1'b0, 1'b0);
		$display("test single and direct done");
	endtask : t_single

	task automatic t_stuck();
		tcfg <= 3'h0;
		burst(2'h0, 6'h02, 8'h03, 8'h64, 1'b1, 1'b1);
		tcfg <= 3'h7;
		repeat (3) @(posedge mclk);
		chk("stuck after off", {31'h0, stuck}, 32'h0);
		chk("count after off", {31'h0, cflt}, 32'h1);
		stby <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("flags in standby", {30'h0, stuck, cflt}, 32'h0);
		stby <= 1'b0;
		tcfg <= 3'h3;
		$display("test stuck drive done");
	endtask : t_stuck

	task automatic t_predrv();
		predrv <= 1'b1;
		burst(2'h0, 6'h02, 8'h03, 8'h04, 1'b0, 1'b0);
		burst(2'h2, 6'h00, 8'h02, 8'h04, 1'b0, 1'b0);
		predrv <= 1'b0;
		$display("test pre-driver done");
	endtask : t_predrv

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_counted();
		t_single();
		t_stuck();
		t_predrv();
		end_sim();
	end
endmodule : tb_top
